// ### core/btob_exec.sv
`timescale 1ns/100ps
module btob_exec
   import btob_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Instruction from fetch; pc is the already incremented counter.
   input wire btob_pkg::btob_instr_t instr_in,
   input wire logic [btob_pkg::BTOB_PC_W-1:0] pc_in,
   // Core state.
   input wire logic ovf_flag,
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [11:0] index_base,
   // Data memory read data, valid in the same cycle as the read request.
   input wire logic [7:0] mem_rdata,
   // Data memory request.
   output btob_pkg::btob_mem_t mem_out,
   // Program counter load and pipeline control.
   output logic pc_load,
   output logic [btob_pkg::BTOB_PC_W-1:0] pc_new,
   output logic flush,
   output logic busy
);
   import btob_pkg::*;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic word_taken;
   logic is_skip;
   logic is_invert;
   logic is_bov;
   logic br_taken;
   logic [3:0] inv_opc;
   logic [7:0] bov_opc;
   logic [2:0] bit_field;
   logic acc_sel;
   logic [BTOB_BYTE_W-1:0] file_field;
   logic [11:0] eff_addr;
   logic [BTOB_PC_W-1:0] offset_x2;
   logic [BTOB_BYTE_W-1:0] flip_byte;
   btob_state_t state_reg;
   logic [2:0] bit_sel_reg;
   logic [11:0] addr_reg;

   // Field slices of the presented word. The branch reuses the low byte,
   // which the invert takes as its file address, as its signed offset.
   assign inv_opc = instr_in.word[BTOB_OPC_HI:BTOB_INV_OPC_LO];
   assign bov_opc = instr_in.word[BTOB_OPC_HI:BTOB_BOV_OPC_LO];
   assign bit_field = instr_in.word[BTOB_BIT_HI:BTOB_BIT_LO];
   assign acc_sel = instr_in.word[BTOB_ACC_BIT];
   assign file_field = instr_in.word[BTOB_FILE_HI:BTOB_FILE_LO];

   // A word is only looked at while the sequencer is idle, so a word that
   // arrives in a flushed cycle or in the read cycle of an invert is never executed.
   assign word_taken = instr_in.valid && (state_reg == BTOB_ST_IDLE);

   // A met skip owns the word outright: whatever opcode the skipped word
   // carries, it must not reach memory or the counter. The skip test is
   // therefore kept out of both opcode decodes.
   assign is_skip = word_taken && instr_in.skip_two_word;
   assign is_invert = word_taken && !instr_in.skip_two_word
                      && (inv_opc == BTOB_OP_INVERT);
   assign is_bov = word_taken && !instr_in.skip_two_word
                   && (bov_opc == BTOB_OP_BRANCH_OVF);

   // The overflow flag alone decides; a clear flag lets the branch retire
   // in its own cycle with no further effect.
   assign br_taken = is_bov && ovf_flag;

   // Sign-extend the offset and double it, since the counter steps in bytes
   // while the offset counts words.
   assign offset_x2 = {{(BTOB_PC_W-BTOB_BYTE_W-1){file_field[BTOB_FILE_HI]}}, file_field,
                       1'b0};

   // Address select: banked, indexed or access bank. The indexed window
   // only exists with the extended set on; without it the low part of the
   // access bank maps straight to bank zero.
   always_comb begin
      if (acc_sel) begin
         eff_addr = {bank_select_reg, file_field};
      end else if (ext_set_en && (file_field <= BTOB_ILO_LIMIT)) begin
         eff_addr = index_base + {BTOB_BANK_ZERO, file_field};
      end else if (file_field >= BTOB_ACCESS_HIGH_BASE) begin
         eff_addr = {BTOB_ACCESS_HIGH_BANK, file_field};
      end else begin
         eff_addr = {BTOB_BANK_ZERO, file_field};
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Read happens this cycle, write lands next; the core counts it as one
   // instruction cycle since fetch of the following word overlaps. The
   // price is that the word behind an invert waits one clock, because the
   // single memory port cannot read one address while writing another.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= BTOB_ST_IDLE;
      end else begin
         case (state_reg)
            BTOB_ST_IDLE: begin
               if (is_skip) begin
                  state_reg <= BTOB_ST_SKIP2;
               end else if (is_invert) begin
                  state_reg <= BTOB_ST_READ;
               end else if (br_taken) begin
                  state_reg <= BTOB_ST_FLUSH;
               end else begin
                  state_reg <= BTOB_ST_IDLE;
               end
            end
            BTOB_ST_READ: begin
               state_reg <= BTOB_ST_IDLE;
            end
            BTOB_ST_FLUSH: begin
               state_reg <= BTOB_ST_IDLE;
            end
            BTOB_ST_SKIP2: begin
               state_reg <= BTOB_ST_FLUSH;
            end
            default: begin
               state_reg <= BTOB_ST_IDLE;
            end
         endcase
      end
   end

   // Latch operand fields for the write-back cycle, since the word on the
   // fetch side has moved on by then.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         bit_sel_reg <= BTOB_BIT_ZERO;
         addr_reg <= BTOB_ADDR_ZERO;
      end else if (is_invert) begin
         bit_sel_reg <= bit_field;
         addr_reg <= eff_addr;
      end
   end

   // ------------------------------------------------------------
   // Memory port
   // ------------------------------------------------------------
   // One lane per data bit: only the lane whose index matches the latched
   // bit field inverts, the other lanes pass the read byte through.
   for (genvar g = 0; g < BTOB_BYTE_W; g++) begin : g_flip
      assign flip_byte[g] = mem_rdata[g] ^ (bit_sel_reg == 3'(g));
   end

   // Read request in the cycle after decode, write-back in the one after.
   // Only the chosen bit changes; no status flag is touched, so no flag
   // output port exists at all.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mem_out <= '0;
      end else begin
         mem_out.rd <= is_invert;
         mem_out.wr <= (state_reg == BTOB_ST_READ);
         if (is_invert) begin
            mem_out.addr <= eff_addr;
         end else begin
            mem_out.addr <= addr_reg;
         end
         if (state_reg == BTOB_ST_READ) begin
            mem_out.wdata <= flip_byte;
         end else begin
            mem_out.wdata <= BTOB_BYTE_ZERO;
         end
      end
   end

   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   // Load strobe: one cycle, and only for a taken branch, so a not-taken
   // branch never disturbs the fetch side.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pc_load <= 1'b0;
      end else begin
         pc_load <= br_taken;
      end
   end

   // Target value: held between branches, so a late reader of the port
   // still sees the last target.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pc_new <= BTOB_PC_RESET;
      end else if (br_taken) begin
         pc_new <= pc_in + offset_x2;
      end
   end

   // ------------------------------------------------------------
   // Flush and busy
   // ------------------------------------------------------------
   // Flush marks each discarded cycle, executed as a no-operation: the word
   // behind a taken branch, and both words of a skipped two-word one.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flush <= 1'b0;
      end else begin
         flush <= br_taken || is_skip
                  || (state_reg == BTOB_ST_SKIP2);
      end
   end

   // Busy tells fetch that the current cycle is owned by this block.
   // It is low exactly when the sequencer is idle, so the fetch side may
   // use it as the acceptance condition for the next word.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
      end else if (state_reg == BTOB_ST_IDLE) begin
         busy <= is_skip || is_invert || br_taken;
      end else begin
         busy <= (state_reg == BTOB_ST_SKIP2);
      end
   end

   // Neither instruction has a status flag result; the overflow flag is
   // only read here and is owned elsewhere in the core.
endmodule : btob_exec

// ### core/btob_pkg.sv
package btob_pkg;
   // ------------------------------------------------------------
   // Instruction encodings
   // ------------------------------------------------------------
   localparam logic [3:0] BTOB_OP_INVERT = 4'h7;
   localparam logic [7:0] BTOB_OP_BRANCH_OVF = 8'hE4;
   localparam logic [7:0] BTOB_ILO_LIMIT = 8'h5F;
   localparam int BTOB_PC_W = 21;
   localparam logic [BTOB_PC_W-1:0] BTOB_PC_STEP = 21'h000002;
   localparam logic [BTOB_PC_W-1:0] BTOB_PC_RESET = 21'h000000;
   localparam logic [7:0] BTOB_BYTE_ZERO = 8'h00;
   localparam logic [11:0] BTOB_ADDR_ZERO = 12'h000;
   localparam logic [7:0] BTOB_ACCESS_HIGH_BASE = 8'h60;
   localparam logic [3:0] BTOB_ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] BTOB_BANK_ZERO = 4'h0;
   localparam logic [2:0] BTOB_BIT_ZERO = 3'h0;

   // ------------------------------------------------------------
   // Instruction field positions and widths
   // ------------------------------------------------------------
   localparam int BTOB_BYTE_W = 8;
   localparam int BTOB_OPC_HI = 15;
   localparam int BTOB_INV_OPC_LO = 12;
   localparam int BTOB_BOV_OPC_LO = 8;
   localparam int BTOB_BIT_HI = 11;
   localparam int BTOB_BIT_LO = 9;
   localparam int BTOB_ACC_BIT = 8;
   localparam int BTOB_FILE_HI = 7;
   localparam int BTOB_FILE_LO = 0;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [15:0] word;
      logic skip_two_word;
   } btob_instr_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } btob_mem_t;

   typedef enum logic [1:0] {
      BTOB_ST_IDLE = 2'b00,
      BTOB_ST_READ = 2'b01,
      BTOB_ST_FLUSH = 2'b10,
      BTOB_ST_SKIP2 = 2'b11
   } btob_state_t;
endpackage : btob_pkg

// ### tb/btob_exec_asserts.sv
`timescale 1ns/100ps
module btob_exec_chk
   import btob_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Inputs.
   input wire btob_pkg::btob_instr_t instr_in,
   input wire logic [btob_pkg::BTOB_PC_W-1:0] pc_in,
   input wire logic ovf_flag,
   input wire logic ext_set_en,
   input wire logic [3:0] bank_select_reg,
   input wire logic [11:0] index_base,
   // Outputs.
   input wire btob_pkg::btob_mem_t mem_out,
   input wire logic pc_load,
   input wire logic [btob_pkg::BTOB_PC_W-1:0] pc_new,
   input wire logic flush,
   input wire logic busy
);
   // Accepted instruction kinds and the branch target they imply.
   wire go = instr_in.valid && !busy && !instr_in.skip_two_word;
   wire inv = go && instr_in.word[15:12] == BTOB_OP_INVERT;
   wire branch_on_ovf_instr = go && instr_in.word[15:8] == BTOB_OP_BRANCH_OVF;
   wire [20:0] tgt = pc_in + {{12{instr_in.word[7]}}, instr_in.word[7:0], 1'b0};
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   a_inv_read: assert property (inv |=> mem_out.rd && !pc_load)
      else $error("no read");
   a_inv_write: assert property (mem_out.rd |=> mem_out.wr && $stable(mem_out.addr))
      else $error("no write");
   a_inv_retire: assert property (inv |=> busy ##1 !busy)
      else $error("invert length");
   a_addr_bank: assert property (inv && instr_in.word[8] |=>
      mem_out.addr == {$past(bank_select_reg), $past(instr_in.word[7:0])}) else $error("bank");
   a_addr_access: assert property (inv && !instr_in.word[8] && !(ext_set_en &&
      instr_in.word[7:0] <= BTOB_ILO_LIMIT) |=> mem_out.addr[7:0] == $past(instr_in.word[7:0])
      && mem_out.addr[11:8] == (mem_out.addr[7:0] >= BTOB_ACCESS_HIGH_BASE
      ? BTOB_ACCESS_HIGH_BANK : 4'h0)) else $error("access");
   a_addr_index: assert property (inv && !instr_in.word[8] && ext_set_en &&
      instr_in.word[7:0] <= BTOB_ILO_LIMIT |=> mem_out.addr == $past(index_base)
      + $past(instr_in.word[7:0])) else $error("index");
   a_ovf_taken: assert property (branch_on_ovf_instr && ovf_flag |=>
      pc_load && flush && pc_new == $past(tgt)) else $error("taken");
   a_ovf_busy: assert property (branch_on_ovf_instr && ovf_flag |=> busy ##1 !busy)
      else $error("branch length");
   a_ovf_idle: assert property (branch_on_ovf_instr && !ovf_flag |=> !pc_load && !flush && !busy)
      else $error("idle");
   a_load_flush: assert property (pc_load |-> flush && !mem_out.wr)
      else $error("flush");
   a_skip_two: assert property (instr_in.valid && !busy && instr_in.skip_two_word |=>
      flush [*2] ##1 !flush) else $error("skip");
   a_skip_quiet: assert property (instr_in.valid && !busy && instr_in.skip_two_word |=>
      !mem_out.rd && !pc_load) else $error("skip executed");
endmodule : btob_exec_chk
bind btob_exec btob_exec_chk i_chk (.mclk(mclk), .arst_n(arst_n), .instr_in(instr_in),
   .pc_in(pc_in), .ovf_flag(ovf_flag), .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
   .index_base(index_base), .mem_out(mem_out), .pc_load(pc_load), .pc_new(pc_new),
   .flush(flush), .busy(busy));

// ### tb/btob_exec_tb_top.sv
`timescale 1ns/100ps
module btob_exec_tb_top;
   import btob_pkg::*;
   logic mclk = 0, arst_n = 0, ovf_flag = 0, ext_set_en = 0, pc_load, flush, busy;
   btob_instr_t instr_in = '0;
   logic [20:0] pc_in = '0, pc_new;
   logic [3:0] bank_select_reg = '0;
   logic [11:0] index_base = '0, ad;
   logic [7:0] mem_rdata, f, sh [4096];
   btob_mem_t mem_out;
   logic [21:0] notes [$], seen;
   logic [31:0] r;
   int err_count = 0, n_tests = 0;
   always #25 mclk = ~mclk;
   btob_exec i_btob_exec (.mclk(mclk), .arst_n(arst_n), .instr_in(instr_in), .pc_in(pc_in),
      .ovf_flag(ovf_flag), .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg),
      .index_base(index_base), .mem_rdata(mem_rdata), .mem_out(mem_out), .pc_load(pc_load),
      .pc_new(pc_new), .flush(flush), .busy(busy));
   btob_mem_model i_btob_mem_model (.mclk(mclk), .mem_out(mem_out), .mem_rdata(mem_rdata));
   task automatic check(input logic [21:0] seen, input logic [21:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   // Holds the word for one cycle, then waits for the block to go idle.
   task automatic issue(input logic [15:0] w, input logic s2);
      int k;
      instr_in = '{1'b1, w, s2};
      @(negedge mclk);
      instr_in.valid = 1'b0;
      // Always let one edge pass with valid low, so the next call never
      // lowers and raises it in the same time step.
      for (k = 0; k == 0 || (busy !== 1'b0 && k < 9); k++) @(negedge mclk);
      if (busy !== 1'b0) begin
         check(1, 0);
         summarize();
      end
   endtask : issue
   // Each write-back or counter load is matched against the oldest note.
   always @(negedge mclk) if (arst_n && (mem_out.wr || pc_load)) begin
      if (notes.size() == 0) begin
         check(1, 0);
      end else begin
         seen = pc_load ? {1'b0, pc_new} : {2'b10, mem_out.addr, mem_out.wdata};
         check(seen, notes.pop_front());
      end
   end
   // Mixed inverts and branches, with file and offset boundaries first.
   initial begin
      foreach (sh[i]) sh[i] = i[7:0] ^ 8'hA5;
      void'($urandom(32'hEBD8));
      repeat (8) @(negedge mclk);
      arst_n = 1;
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         {ext_set_en, ovf_flag, bank_select_reg, index_base} = r[31:14];
         pc_in = {r[13:0], r[6:0]};
         f = i < 8 ? 8'h5D + 8'(i / 2) : r[7:0];
         if (i % 2) begin
            f = i == 1 ? 8'h80 : i == 3 ? 8'h7F : f;
            if (ovf_flag) notes.push_back({1'b0, pc_in + {{12{f[7]}}, f, 1'b0}});
            issue({BTOB_OP_BRANCH_OVF, f}, 1'b0);
         end else begin
            ad = r[8] ? {bank_select_reg, f} : (ext_set_en && f <= 8'h5F) ? index_base + f
               : {f >= 8'h60 ? 4'hF : 4'h0, f};
            sh[ad] ^= 8'h01 << r[11:9];
            notes.push_back({2'b10, ad, sh[ad]});
            issue({BTOB_OP_INVERT, r[11:8], f}, 1'b0);
         end
         // A skipped word that looks like an invert must leave memory alone.
         if (i % 10 == 0) issue({BTOB_OP_INVERT, r[11:0]}, 1'b1);
      end
      repeat (4) @(negedge mclk);
      check(22'(notes.size()), 0);
      summarize();
   end
endmodule : btob_exec_tb_top

// ### tb/btob_mem_model.sv
`timescale 1ns/100ps
module btob_mem_model
   import btob_pkg::*;
(
   // Clock and memory request.
   input wire logic mclk,
   input wire btob_pkg::btob_mem_t mem_out,
   // Read data.
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [4096];
   logic rd_q;
   // Known fill; outside the read window the data is inverted, never stale.
   initial foreach (mem[i]) mem[i] = i[7:0] ^ 8'hA5;
   assign mem_rdata = (rd_q || mem_out.rd) ? mem[mem_out.addr] : ~mem[mem_out.addr];
   // Write-back and read window.
   always @(posedge mclk) begin
      rd_q <= mem_out.rd;
      if (mem_out.wr) mem[mem_out.addr] <= mem_out.wdata;
   end
endmodule : btob_mem_model
